// ### rtl/ppm_port1_pin_mode.sv
// Indirect per-pin mode register of port 1 with an AXI4-Lite slave.
`timescale 1ns/1ps
// Overview of operation
// - Update write stores mode for indexed pin only.
// - Direction zero updates output, one updates input.
// - Pointer write latches index and direction only.
// - Mode bits ignored on pointer writes.
// - Read returns pointed pin mode, bits 7:5.
// - Output codes 000 normal, 011 high drive.
// - Input codes: none, pulldown, pullup, off.
// - Index values zero..seven select pins zero..seven.
`include "ppm_cfg.svh"
module ppm_port1_pin_mode
  import ppm_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [11:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output ppm_pins_s o_pins
);

  // ****************************************************
  // Pin mode storage
  // ****************************************************
  logic [2:0] out_mode [8];
  logic [1:0] in_mode [8];
  logic [2:0] next_out_mode [8];
  logic [1:0] next_in_mode [8];
  // The read pointer survives any number of reads; only a pointer write
  // moves it.
  ppm_ptr_s ptr;
  ppm_ptr_s next_ptr;

  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [11:0] aw_addr, next_aw_addr;
  logic [7:0] w_byte, next_w_byte;
  logic w_lane0, next_w_lane0;
  logic [1:0] next_bresp, next_rresp;
  logic next_bvalid, next_rvalid;
  logic [31:0] next_rdata;
  ppm_pins_s next_pins;
  logic do_write;

  function automatic logic [7:0] ppm_read_byte(input ppm_ptr_s p,
      input logic [2:0] om, input logic [1:0] im);
    // Bits that are write-only controls always read as zero.
    ppm_read_byte = 8'h00;
    if (p.dir == PPM_DIR_IN) begin
      ppm_read_byte[6:5] = im;
    end else begin
      ppm_read_byte[7:5] = om;
    end
  endfunction

  // Only word-aligned accesses exist on this bus, so the two low address
  // bits take no part in decoding.
  function automatic logic ppm_hit(input logic [11:0] a,
      input logic [11:0] reg_addr);
    ppm_hit = (a[11:2] == reg_addr[11:2]);
  endfunction

  function automatic logic [2:0] ppm_idx(input logic [7:0] b);
    ppm_idx = b[`PPM_IDX_HI:`PPM_IDX_LO];
  endfunction

  // ****************************************************
  // Bus slave and register update
  // ****************************************************
  // Address and data are captured independently; a write completes
  // only when both are held and no response is pending.
  assign do_write = aw_held && w_held && !o_bvalid;
  // Write and read paths are independent; either may be busy alone.

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_byte = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid = o_bvalid;
    next_bresp = o_bresp;
    next_rvalid = o_rvalid;
    next_rresp = o_rresp;
    next_rdata = o_rdata;
    next_ptr = ptr;
    next_out_mode = out_mode;
    next_in_mode = in_mode;
    if (i_awvalid && o_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      next_w_held = 1'b1;
      next_w_byte = i_wdata[7:0];
      next_w_lane0 = i_wstrb[0];
    end
    if (o_bvalid && i_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `PPM_AXI_SLVERR;
      if (ppm_hit(aw_addr, `PPM_ADDR_PORT1_PIN_MODE_INDIRECT)) begin
        next_bresp = `PPM_AXI_OKAY;
        // Without byte lane zero the write is acknowledged but changes
        // nothing, so a partial word write to the upper lanes only cannot disturb any pin.
        if (w_lane0) begin
          if (w_byte[`PPM_RDPTR_BIT]) begin
            next_ptr.idx = ppm_idx(w_byte);
            next_ptr.dir = ppm_dir_e'(w_byte[`PPM_DIR_BIT]);
          end else if (w_byte[`PPM_DIR_BIT]) begin
            next_in_mode[ppm_idx(w_byte)] =
              w_byte[`PPM_IN_HI:`PPM_MODE_LO];
          end else begin
            next_out_mode[ppm_idx(w_byte)] =
              w_byte[`PPM_MODE_HI:`PPM_MODE_LO];
          end
        end
      end
    end
    if (o_rvalid && i_rready) begin
      next_rvalid = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      next_rvalid = 1'b1;
      next_rresp = `PPM_AXI_OKAY;
      next_rdata = 32'h0000_0000;
      if (ppm_hit(i_araddr, `PPM_ADDR_PORT1_PIN_MODE_INDIRECT)) begin
        next_rdata[7:0] = ppm_read_byte(ptr, out_mode[ptr.idx],
          in_mode[ptr.idx]);
      end else if (ppm_hit(i_araddr, `PPM_ADDR_PIN_STATE)) begin
        // Pin state is a read-only view of the decoded controls.
        next_rdata = o_pins;
      end else begin
        next_rresp = `PPM_AXI_SLVERR;
      end
    end
  end

  // ****************************************************
  // Decoded per-pin buffer controls
  // ****************************************************
  // Illegal output codes are stored as written and read back, but only
  // the high drive code turns on the strong driver.
  // The controls lag the stored modes by one edge so each leaves a flop.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      next_pins.out_hi[i] = (out_mode[i] == `PPM_OUT_HIGH);
      next_pins.in_up[i] = (in_mode[i] == `PPM_IN_PULLUP);
      next_pins.in_down[i] = (in_mode[i] == `PPM_IN_PULLDOWN);
      next_pins.in_off[i] = (in_mode[i] == `PPM_IN_OFF);
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_byte <= `PPM_RST_PORT1_PIN_MODE_INDIRECT;
      w_lane0 <= 1'b0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_arready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= `PPM_AXI_OKAY;
      o_rvalid <= 1'b0;
      o_rresp <= `PPM_AXI_OKAY;
      o_rdata <= 32'h0000_0000;
      o_pins <= '0;
      ptr <= '0;
      // Every pin leaves reset as a normal drive output and pull-free input.
      for (int i = 0; i < 8; i++) begin
        out_mode[i] <= `PPM_RST_OUT_MODE;
        in_mode[i] <= `PPM_RST_IN_MODE;
      end
    end else if (i_ce) begin
      // Enable low holds every register, outputs included, so a stalled
      // handshake resumes exactly where it stopped.
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_byte <= next_w_byte;
      w_lane0 <= next_w_lane0;
      o_awready <= !next_aw_held;
      o_wready <= !next_w_held;
      // A new read is taken only once the last data was accepted, so
      // read data never needs a second buffer.
      o_arready <= !next_rvalid;
      o_bvalid <= next_bvalid;
      o_bresp <= next_bresp;
      o_rvalid <= next_rvalid;
      o_rresp <= next_rresp;
      o_rdata <= next_rdata;
      o_pins <= next_pins;
      ptr <= next_ptr;
      out_mode <= next_out_mode;
      in_mode <= next_in_mode;
    end
  end

endmodule

// ### rtl/ppm_cfg.svh
// Offsets, field positions and reset values of the pin mode block.
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH
// Printed offset 0x9f is not a multiple of four, so it is an index.
`define PPM_IDX_PORT1_PIN_MODE_INDIRECT 8'h9f
`define PPM_ADDR_PORT1_PIN_MODE_INDIRECT 12'h27c
`define PPM_ADDR_PIN_STATE 12'h400
`define PPM_RST_PORT1_PIN_MODE_INDIRECT 8'h00
`define PPM_RST_OUT_MODE 3'h0
`define PPM_RST_IN_MODE 2'h0
`define PPM_MODE_HI 7
`define PPM_MODE_LO 5
`define PPM_IN_HI 6
`define PPM_IN_PULLDOWN 2'h1
`define PPM_IN_PULLUP 2'h2
`define PPM_IN_OFF 2'h3
`define PPM_DIR_BIT 4
`define PPM_RDPTR_BIT 3
`define PPM_IDX_HI 2
`define PPM_IDX_LO 0
`define PPM_OUT_NORMAL 3'h0
`define PPM_OUT_HIGH 3'h3
`define PPM_AXI_OKAY 2'h0
`define PPM_AXI_SLVERR 2'h2
`endif

// ### rtl/ppm_pkg.sv
// Types of the pin mode block.
package ppm_pkg;
  typedef enum logic {PPM_DIR_OUT, PPM_DIR_IN} ppm_dir_e;
  typedef struct packed {
    logic [2:0] idx;
    ppm_dir_e dir;
  } ppm_ptr_s;
  typedef struct packed {
    logic [7:0] out_hi;
    logic [7:0] in_up;
    logic [7:0] in_down;
    logic [7:0] in_off;
  } ppm_pins_s;
endpackage

// ### tb/ppm_chk.sv
// Checker of bus handshakes and pin controls of the pin mode block.
`timescale 1ns/1ps
module ppm_chk import ppm_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire ppm_pins_s o_pins
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_aw;
    i_awvalid && o_awready && i_wvalid && o_wready && !o_bvalid;
  endsequence
  sequence s_ar; i_arvalid && o_arready; endsequence
  sequence s_wbusy; !o_awready && !o_wready && !o_bvalid; endsequence
  sequence s_wdone; o_awready && o_wready && o_bvalid; endsequence
  property p_wr; s_aw |-> ##2 o_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("bvalid late");
  property p_busy; s_aw |=> s_wbusy ##1 s_wdone; endproperty
  a_busy: assert property (p_busy) else $error("awready early");
  property p_rd; s_ar |=> o_rvalid && !o_arready; endproperty
  a_rd: assert property (p_rd) else $error("rvalid late");
  property p_bend; o_bvalid && i_bready |=> !o_bvalid; endproperty
  a_bend: assert property (p_bend) else $error("bvalid stuck");
  property p_rend; o_rvalid && i_rready |=> !o_rvalid; endproperty
  a_rend: assert property (p_rend) else $error("rvalid stuck");
  property p_arlo; o_rvalid |-> !o_arready; endproperty
  a_arlo: assert property (p_arlo) else $error("arready high");
  property p_excl; (o_pins.in_up & o_pins.in_down) == 8'h00; endproperty
  a_excl: assert property (p_excl) else $error("pull clash");
  property p_cause;
    !$stable(o_pins) |-> $past(o_bvalid) || $past(o_bvalid, 2)
      || $past(o_bvalid, 3) || $past(o_bvalid, 4);
  endproperty
  a_cause: assert property (p_cause) else $error("pins moved");
endmodule
bind ppm_port1_pin_mode ppm_chk i_chk (.*);

// ### tb/testbench.sv
// Self-checking bench of the port 1 pin mode block.
`timescale 1ns/1ps
`include "ppm_cfg.svh"
module testbench
  import ppm_pkg::*;
;
  logic i_ref_clk, i_rst, i_ce, i_awvalid, i_wvalid, i_bready, i_arvalid;
  logic i_rready, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [11:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0] i_wstrb;
  logic [1:0] o_bresp, o_rresp;
  ppm_pins_s o_pins;
  int bad_count, checked;
  localparam logic [11:0] RG = `PPM_ADDR_PORT1_PIN_MODE_INDIRECT;
  ppm_port1_pin_mode i_dut (.*);
  task chk(input logic [33:0] g, e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %0t %h %h", $time, g, e);
    end
  endtask
  task give_verdict;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] e = 2'h0);
    @(posedge i_ref_clk);
    {i_awaddr, i_araddr, i_wdata} <= {a, a, d};
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} <= {w, w, w, !w, !w};
    // Each valid drops once taken; ready stays up until the answer.
    do begin
      @(posedge i_ref_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      if (o_arready) i_arvalid <= 1'b0;
    end while (!(o_bvalid || o_rvalid));
    {i_bready, i_rready} <= 2'h0;
    chk(w ? {o_bresp, 32'h0000_0000} : {o_rresp, o_rdata},
      {e, w ? 32'h0000_0000 : d});
  endtask
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    repeat (3000) @(posedge i_ref_clk);
    bad_count++;
    give_verdict;
  end
  initial begin
    {i_rst, i_ce, i_wstrb, i_awvalid, i_wvalid, i_bready} = 9'h1f8;
    {i_arvalid, i_rready, i_awaddr, i_araddr, i_wdata} = '0;
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    xfer(1'b0, RG, 32'h0000_0000);
    for (int p = 0; p < 8; p++) begin
      xfer(1'b1, RG, 32'({1'b0, {2{p[0]}}, 2'h0, p[2:0]}));
      xfer(1'b1, RG, 32'({1'b0, p[1:0], 2'h2, p[2:0]}));
    end
    repeat (3) @(posedge i_ref_clk);
    xfer(1'b0, `PPM_ADDR_PIN_STATE, 32'hAA44_2288);
    for (int p = 0; p < 8; p++) begin
      xfer(1'b1, RG, 32'({3'h7, p[1], 1'b1, p[2:0]}));
      xfer(1'b0, RG, 32'({1'b0, (p[1] ? p[1:0] : {2{p[0]}}), 5'h00}));
    end
    xfer(1'b0, `PPM_ADDR_PIN_STATE, 32'hAA44_2288);
    chk(34'(o_pins), 34'h0_AA44_2288);
    i_wstrb <= 4'h0;
    xfer(1'b1, RG, 32'h0000_0060);
    i_wstrb <= 4'hf;
    xfer(1'b1, RG, 32'h0000_0008);
    xfer(1'b0, RG, 32'h0000_0000);
    xfer(1'b1, 12'h010, 32'h0000_00ff, `PPM_AXI_SLVERR);
    xfer(1'b0, 12'h010, 32'h0000_0000, `PPM_AXI_SLVERR);
    give_verdict;
  end
endmodule
